// ==== logic/imw_regs.svh ====
// Register map, field positions and constants for the idle wake controller
`ifndef IMW_REGS_SVH
`define IMW_REGS_SVH
`define IMW_ADDR_CTRL 8'h00
`define IMW_ADDR_CLKSEL 8'h04
`define IMW_ADDR_STATUS 8'h08
`define IMW_ADDR_PRIO 8'h0c
`define IMW_CTRL_STANDBY 0
`define IMW_CTRL_STOPSEL 1
`define IMW_CTRL_PINNMI_M 2
`define IMW_CTRL_WDTNMI_M 3
`define IMW_CTRL_MASKABLE_M 4
`define IMW_CTRL_RESET 32'h0000_0000
`define IMW_SEL_TB_WATCH 0
`define IMW_SEL_WT_MAIN 1
`define IMW_SEL_T8_PIN 2
`define IMW_SEL_T8_TBOUT 4
`define IMW_SEL_H1_SUB 6
`define IMW_SEL_WDT2_SUB 7
`define IMW_SEL_SS_EXT 8
`define IMW_SEL_UA0_EXT 10
`define IMW_SEL_RTO_TRIG 11
`define IMW_SEL_SUB_USED 13
`define IMW_SEL_RESET 32'h0000_0000
`define IMW_NOPRIO 4'hf
`define IMW_HSIZE_WORD 3'h2
`endif

// ==== logic/imw_pkg.sv ====
// Types for the idle wake controller
`default_nettype none
package imw_pkg;
    typedef enum logic [2:0] {
        IMW_RUN = 3'b001,
        IMW_IDLE = 3'b010,
        IMW_WAKE = 3'b100
    } imw_state_t;
    typedef struct packed {
        logic wake;
        logic ack;
        logic branch;
        logic is_nmi;
    } imw_resume_t;
    typedef struct packed {
        logic cpu;
        logic intc;
        logic timer_p;
        logic timer_a;
        logic timer_b;
        logic [1:0] timer8;
        logic timer_h0;
        logic timer_h1;
        logic watch;
        logic wdt1;
        logic wdt2;
        logic [1:0] sync_ser;
        logic auto_ser;
        logic async0;
        logic async1;
        logic twowire;
        logic conv;
        logic rt_out;
    } imw_gate_t;
endpackage
`default_nettype wire

// ==== logic/imw_gate.sv ====
// Per-unit clock enables while idle
`timescale 1ns/100ps
`default_nettype none
`include "imw_regs.svh"
module imw_gate (
    input wire logic idle_i,
    input wire logic [31:0] sel_i,
    output var imw_pkg::imw_gate_t run_o
);
    logic sub;
    logic tb_run;
    always_comb begin
        sub = sel_i[`IMW_SEL_SUB_USED];
        tb_run = sel_i[`IMW_SEL_TB_WATCH]
            & (sub | sel_i[`IMW_SEL_WT_MAIN]);
        run_o = '1;
        if (idle_i) begin
            run_o.cpu = 1'b0;
            run_o.intc = 1'b0;
            run_o.timer_p = 1'b0;
            run_o.timer_h0 = 1'b0;
            run_o.wdt1 = 1'b0;
            run_o.timer_a = 1'b0;
            run_o.timer_b = tb_run;
            for (int m = 0; m < 2; m++) begin
                run_o.timer8[m] = sel_i[`IMW_SEL_T8_PIN + m]
                    | (sel_i[`IMW_SEL_T8_TBOUT + m] & tb_run);
                run_o.sync_ser[m] = sel_i[`IMW_SEL_SS_EXT + m];
            end
            run_o.timer_h1 = sub & sel_i[`IMW_SEL_H1_SUB];
            run_o.wdt2 = sub & sel_i[`IMW_SEL_WDT2_SUB];
            run_o.watch = sub | sel_i[`IMW_SEL_WT_MAIN];
            run_o.async0 = sel_i[`IMW_SEL_UA0_EXT];
            run_o.async1 = 1'b0;
            run_o.auto_ser = 1'b0;
            run_o.twowire = 1'b0;
            run_o.conv = 1'b0;
            run_o.rt_out = run_o.timer8[sel_i[`IMW_SEL_RTO_TRIG]];
        end
    end
endmodule // imw_gate
`default_nettype wire

// ==== logic/imw_top.sv ====
// Idle mode entry, wake arbitration and AHB-Lite control registers
//
// The implementer's own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "imw_regs.svh"
module imw_top #(
    parameter int PRIO_W = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic hsel_i,
    input wire logic [7:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic pin_nmi_i,
    input wire logic wdt_nmi_i,
    input wire logic irq_valid_i,
    input wire logic [PRIO_W-1:0] irq_prio_i,
    input wire logic in_service_i,
    input wire logic [PRIO_W-1:0] service_prio_i,
    input wire logic interrupts_enabled_state_i,
    input wire logic [15:0] port_out_i,
    output logic [15:0] port_out_o,
    output logic idle_o,
    output logic wake_o,
    output logic ack_o,
    output logic branch_o,
    output logic ack_nmi_o,
    output var imw_pkg::imw_gate_t unit_run_o
);
    if (PRIO_W < 1 || PRIO_W > 8) begin : g_prio_chk
        $error("PRIO_W out of range");
    end

    imw_pkg::imw_state_t state_q, state_d;
    logic [31:0] ctrl_q, ctrl_d;
    logic [31:0] sel_q, sel_d;
    logic [31:0] rdata_q, rdata_d;
    logic [15:0] port_q, port_d;
    logic [7:0] addr_q, addr_d;
    logic wr_q, wr_d;
    imw_pkg::imw_resume_t res_q, res_d;
    imw_pkg::imw_resume_t arb;
    logic nmi_ok;
    logic mask_ok;
    logic go_idle;
    logic [31:0] status_w;

    // Decodes a transfer accepted in the current address phase
    function automatic logic take(input logic sel, input logic [1:0] tr, input logic rdy);
        take = sel & tr[1] & rdy;
    endfunction

    // Wake arbitration
    always_comb begin
        nmi_ok = (pin_nmi_i & ~ctrl_q[`IMW_CTRL_PINNMI_M])
            | (wdt_nmi_i & ~ctrl_q[`IMW_CTRL_WDTNMI_M]);
        mask_ok = irq_valid_i & ~ctrl_q[`IMW_CTRL_MASKABLE_M];
        arb = '0;
        arb.wake = nmi_ok | mask_ok;
        arb.is_nmi = nmi_ok;
        if (nmi_ok) begin
            arb.ack = 1'b1;
            arb.branch = 1'b1;
        end else if (mask_ok) begin
            arb.ack = interrupts_enabled_state_i
                & (~in_service_i | (irq_prio_i < service_prio_i));
            arb.branch = arb.ack;
        end
    end

    // Idle state machine
    always_comb begin
        go_idle = ctrl_q[`IMW_CTRL_STANDBY] & ~ctrl_q[`IMW_CTRL_STOPSEL];
        state_d = state_q;
        res_d = res_q;
        unique case (state_q)
            imw_pkg::IMW_RUN: begin
                // Last resume kept for status readback
                if (go_idle) begin
                    state_d = imw_pkg::IMW_IDLE;
                end
            end
            imw_pkg::IMW_IDLE: begin
                if (arb.wake) begin
                    state_d = imw_pkg::IMW_WAKE;
                    res_d = arb;
                end
            end
            imw_pkg::IMW_WAKE: begin
                state_d = imw_pkg::IMW_RUN;
            end
            default: begin
                state_d = imw_pkg::IMW_RUN;
            end
        endcase
    end

    // Port hold and register access
    always_comb begin
        port_d = (state_q == imw_pkg::IMW_IDLE) ? port_q : port_out_i;
        ctrl_d = ctrl_q;
        sel_d = sel_q;
        if (state_q == imw_pkg::IMW_IDLE && arb.wake) begin
            ctrl_d[`IMW_CTRL_STANDBY] = 1'b0;
        end
        if (wr_q) begin
            unique case (addr_q)
                `IMW_ADDR_CTRL: ctrl_d = hwdata_i;
                `IMW_ADDR_CLKSEL: sel_d = hwdata_i;
                default: ;
            endcase
        end
        addr_d = addr_q;
        wr_d = 1'b0;
        if (take(hsel_i, htrans_i, hready_i)) begin
            addr_d = haddr_i;
            // Only whole-word writes reach a register
            wr_d = hwrite_i & (hsize_i == `IMW_HSIZE_WORD);
        end
        status_w = '0;
        status_w[2:0] = state_q;
        status_w[7:4] = {res_q.is_nmi, res_q.branch, res_q.ack, res_q.wake};
        rdata_d = '0;
        if (take(hsel_i, htrans_i, hready_i) && !hwrite_i) begin
            unique case (haddr_i)
                `IMW_ADDR_CTRL: rdata_d = ctrl_q;
                `IMW_ADDR_CLKSEL: rdata_d = sel_q;
                `IMW_ADDR_STATUS: rdata_d = status_w;
                `IMW_ADDR_PRIO: rdata_d = 32'(service_prio_i);
                default: rdata_d = '0;
            endcase
        end
    end

    // CPU state and RAM live elsewhere; their clock is gated, never reset here
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= imw_pkg::IMW_RUN;
            ctrl_q <= `IMW_CTRL_RESET;
            sel_q <= `IMW_SEL_RESET;
            res_q <= '0;
            rdata_q <= '0;
            port_q <= '0;
            addr_q <= '0;
            wr_q <= 1'b0;
        end else begin
            state_q <= state_d;
            ctrl_q <= ctrl_d;
            sel_q <= sel_d;
            res_q <= res_d;
            rdata_q <= rdata_d;
            port_q <= port_d;
            addr_q <= addr_d;
            wr_q <= wr_d;
        end
    end

    imw_gate u_gate (
        .idle_i(state_q == imw_pkg::IMW_IDLE),
        .sel_i(sel_q),
        .run_o(unit_run_o)
    );

    assign hrdata_o = rdata_q;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign port_out_o = port_q;
    assign idle_o = (state_q == imw_pkg::IMW_IDLE);
    assign wake_o = (state_q == imw_pkg::IMW_WAKE) & res_q.wake;
    assign ack_o = (state_q == imw_pkg::IMW_WAKE) & res_q.ack;
    assign branch_o = (state_q == imw_pkg::IMW_WAKE) & res_q.branch;
    assign ack_nmi_o = (state_q == imw_pkg::IMW_WAKE) & res_q.is_nmi;
endmodule // imw_top
`default_nettype wire

// ==== verification/imw_top_sva.sv ====
// Port checker for the idle wake controller
`timescale 1ns/100ps
`default_nettype none
module imw_top_chk #(parameter int PRIO_W = 4) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [PRIO_W-1:0] irq_prio_i,
    input wire logic in_service_i,
    input wire logic [PRIO_W-1:0] service_prio_i,
    input wire logic interrupts_enabled_state_i,
    input wire logic [15:0] port_out_o,
    input wire logic idle_o,
    input wire logic wake_o,
    input wire logic ack_o,
    input wire logic branch_o,
    input wire logic ack_nmi_o,
    input wire imw_pkg::imw_gate_t unit_run_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    AST_WAKE_FROM_IDLE: assert property (wake_o |-> $past(idle_o) && !idle_o ##1 !wake_o)
        else $error("bad wake");
    AST_NMI_TAKEN: assert property (ack_nmi_o |-> wake_o && ack_o && branch_o)
        else $error("bad nmi");
    AST_BRANCH_IS_ACK: assert property (wake_o |-> branch_o == ack_o)
        else $error("bad branch");
    AST_DI_NEXT: assert property (wake_o && !ack_nmi_o
        && !$past(interrupts_enabled_state_i) |-> !branch_o) else $error("bad di");
    AST_LOW_PRIO: assert property (wake_o && !ack_nmi_o && $past(in_service_i)
        && $past(irq_prio_i) >= $past(service_prio_i) |-> !ack_o) else $error("bad prio");
    AST_PORT_FROZEN: assert property (idle_o && $past(idle_o) |-> $stable(port_out_o))
        else $error("bad port");
    AST_IDLE_GATES: assert property (idle_o
        |-> !unit_run_o.cpu && !unit_run_o.intc && !unit_run_o.timer_p
        && !unit_run_o.timer_h0 && !unit_run_o.wdt1 && !unit_run_o.timer_a)
        else $error("bad gate");
    AST_AWAKE_RUNS: assert property (!idle_o |-> &unit_run_o)
        else $error("bad run");
    AST_RESET_CLEARS: assert property (disable iff (1'b0) rst_i |=> !idle_o && !wake_o)
        else $error("bad reset");
    COV_ACK: cover property (wake_o && ack_o && !ack_nmi_o);
    COV_WAKE_ONLY: cover property (wake_o && !ack_o);
    COV_NMI: cover property (ack_nmi_o);
endmodule // imw_top_chk
bind imw_top imw_top_chk #(.PRIO_W(PRIO_W)) u_chk (.clk_i, .rst_i, .irq_prio_i, .in_service_i,
    .service_prio_i, .interrupts_enabled_state_i, .port_out_o, .idle_o, .wake_o, .ack_o,
    .branch_o, .ack_nmi_o, .unit_run_o);
`default_nettype wire

// ==== verification/imw_cpu_model.sv ====
// Behavioural CPU side raising wake requests
`timescale 1ns/100ps
`default_nettype none
module imw_cpu_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ack_i,
    output logic [2:0] req_o = 3'h0,
    output logic [3:0] prio_o = 4'h0
);
    task automatic raise(input logic [2:0] src, input logic [3:0] p);
        req_o <= src;
        prio_o <= p;
        @(posedge clk_i);
    endtask
    // Taken request is consumed, a refused one stays pending
    always @(posedge clk_i) begin
        if (rst_i || ack_i) begin
            req_o <= 3'h0;
        end
    end
endmodule // imw_cpu_model
`default_nettype wire

// ==== verification/imw_top_tb.sv ====
// Self-checking bench for the idle wake controller
`timescale 1ns/100ps
`default_nettype none
`include "imw_regs.svh"
module imw_top_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic insvc = 1'b0;
    logic ei = 1'b0;
    logic [15:0] pin = 16'h0;
    logic [31:0] hrdata, junk;
    logic [15:0] pout;
    logic hrdy, hresp, idle, wake, ack, branch, acknmi;
    logic [2:0] req;
    logic [3:0] prio;
    imw_pkg::imw_gate_t run;
    int n_errors = 0;
    int total_checks = 0;
    imw_top u_dut (.clk_i, .rst_i, .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
        .hreadyout_o(hrdy), .hresp_o(hresp), .pin_nmi_i(req[2]), .wdt_nmi_i(req[1]),
        .irq_valid_i(req[0]), .irq_prio_i(prio), .in_service_i(insvc), .service_prio_i(4'h8),
        .interrupts_enabled_state_i(ei), .port_out_i(pin), .port_out_o(pout), .idle_o(idle),
        .wake_o(wake), .ack_o(ack), .branch_o(branch), .ack_nmi_o(acknmi), .unit_run_o(run));
    imw_cpu_model u_cpu (.clk_i, .rst_i, .ack_i(ack), .req_o(req), .prio_o(prio));
    initial forever #25 clk_i = ~clk_i;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic until_high(ref logic s, input int n);
        int k = 0;
        while (s !== 1'b1) begin
            @(posedge clk_i);
            k++;
            if (k > n) begin
                chk(32'h0, 32'h1);
                conclude();
            end
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] r);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge clk_i);
        until_high(hrdy, 50);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk_i);
        until_high(hrdy, 50);
        r = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(a, 1'b0, 32'h0, r);
        chk(r, e);
    endtask
    task automatic go_idle(input logic [31:0] ctrl);
        bus(`IMW_ADDR_CTRL, 1'b1, ctrl, junk);
        @(posedge clk_i);
        until_high(idle, 5);
        pin <= ~pin;
        @(posedge clk_i);
        chk({16'h0, pout}, {16'h0, ~pin});
    endtask
    task automatic leave();
        u_cpu.raise(3'h7, 4'h0);
        until_high(wake, 5);
        chk(run.cpu, 1'b1);
        @(posedge clk_i);
        u_cpu.raise(3'h0, 4'h0);
    endtask
    task automatic t_wake(input logic [2:0] src, input logic e, input logic s,
        input logic [3:0] p, input logic [2:0] exp);
        ei <= e;
        insvc <= s;
        go_idle(32'h1);
        u_cpu.raise(src, p);
        until_high(wake, 5);
        chk({ack, branch, acknmi}, exp);
        @(posedge clk_i);
        u_cpu.raise(3'h0, 4'h0);
    endtask
    task automatic t_mask();
        for (int i = 0; i < 3; i++) begin
            go_idle(32'h1 | (32'h4 << i));
            u_cpu.raise(3'h4 >> i, 4'h4);
            repeat (6) @(posedge clk_i);
            chk(idle, 1'b1);
            leave();
        end
    endtask
    task automatic t_gate(input logic [31:0] sel, input logic [31:0] exp);
        bus(`IMW_ADDR_CLKSEL, 1'b1, sel, junk);
        go_idle(32'h1);
        chk(run, exp);
        leave();
    endtask
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(`IMW_ADDR_CTRL, `IMW_CTRL_RESET);
        rd(`IMW_ADDR_CLKSEL, `IMW_SEL_RESET);
        bus(8'h10, 1'b1, 32'hffff_ffff, junk);
        rd(8'h10, 32'h0);
        bus(`IMW_ADDR_CTRL, 1'b1, 32'h3, junk);
        repeat (4) @(posedge clk_i);
        chk(idle, 1'b0);
        t_wake(3'h4, 1'b0, 1'b1, 4'hc, 3'h7);
        t_wake(3'h2, 1'b1, 1'b0, 4'h0, 3'h7);
        t_wake(3'h1, 1'b1, 1'b0, 4'h4, 3'h6);
        t_wake(3'h1, 1'b1, 1'b1, 4'hc, 3'h0);
        t_wake(3'h1, 1'b1, 1'b1, 4'h4, 3'h6);
        rd(`IMW_ADDR_STATUS, 32'h71);
        rd(`IMW_ADDR_PRIO, 32'h8);
        t_wake(3'h1, 1'b0, 1'b0, 4'h4, 3'h0);
        t_mask();
        t_gate(32'h2fff, 32'h0edd1);
        t_gate(32'h2031, 32'h0e401);
        t_gate(32'h0, 32'h0);
        t_gate(32'h0013, 32'h0a401);
        t_gate(32'h0011, 32'h0);
        go_idle(32'h1);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk(idle, 1'b0);
        rd(`IMW_ADDR_CTRL, 32'h0);
        conclude();
    end
endmodule // imw_top_tb
`default_nettype wire
